// ---- src/monitor_system_commands.sv ----
/*
 * Monitor system functions behind a strobe register port: backplane
 * reset control, time of day, elapsed-time counters, version, supply
 * source, and a read-to-clear interrupt status.
 * Assumes a 250 MHz clock, power-up reset on reset, and asynchronous
 * backplane and supply pins that are synchronised here.
 */
// The strobed register port and the register offsets are this design's own decisions.
module monitor_system_commands import sys_cmd_pkg::*; #(
    parameter int unsigned TICK_CYCLES = TICK_CYCLES_DEF
) (
    // Clocking
    input wire logic clk,
    input wire logic reset,
    input wire logic ce,
    // Register port
    input wire logic [ADDR_W-1:0] addr,
    input wire logic [DATA_W-1:0] wdata,
    input wire logic wr,
    input wire logic rd,
    output logic [DATA_W-1:0] rdata,
    output logic irq,
    // Backplane reset line, open drain, active low
    input wire logic sysreset_n_i,
    output logic sysreset_n_o,
    output logic sysreset_n_oe,
    // Supply pins
    input wire logic chassis_power_good,
    input wire logic external_supply,
    // Monitor-side controls
    output logic vif_init,
    output logic monitor_reset,
    output logic ui_enable,
    output logic chassis_power_cmd
);
    typedef struct packed {
        logic reset_en;
        logic power_cmd;
        logic [IRQ_W-1:0] irq_status;
        logic [IRQ_W-1:0] irq_mask;
        logic [DATA_W-1:0] rdata;
        seq_t seq;
        logic [7:0] pulse_cnt;
        logic [TICK_W-1:0] tick_cnt;
        logic pg_prev;
    } state_t;

    state_t s_q;
    state_t s_d;
    logic [2:0] pins_s;
    logic sysrst_s;
    logic pg_s;
    logic ext_s;
    logic hold;
    logic sys_act;
    logic mon_rst;
    logic wr_ok;
    logic rd_ok;
    logic tick;
    logic [1:0] en_arg;
    logic [1:0] pw_arg;
    hms_t set_time;
    logic time_ok;
    logic [IRQ_W-1:0] events;

    hms_ifc tod_if();
    hms_ifc svc_if();
    hms_ifc on_if();

    // ---------------------------------------------------------------
    // Pin synchronisers and counters
    // ---------------------------------------------------------------
    sync2 #(.W(3)) u_pins (
        .clk(clk),
        .reset(reset),
        .ce(ce),
        .d({~sysreset_n_i, chassis_power_good, external_supply}),
        .q(pins_s)
    );
    assign sysrst_s = pins_s[2];
    assign pg_s = pins_s[1];
    assign ext_s = pins_s[0];

    hms_counter #(.WRAP_DAY(1'b1)) u_tod (
        .clk(clk),
        .reset(reset),
        .ce(ce),
        .hms(tod_if.cnt)
    );
    // No non-volatile store here: the service count restarts at power up
    hms_counter #(.WRAP_DAY(1'b0)) u_svc (
        .clk(clk),
        .reset(reset),
        .ce(ce),
        .hms(svc_if.cnt)
    );
    hms_counter #(.WRAP_DAY(1'b0)) u_on (
        .clk(clk),
        .reset(reset),
        .ce(ce),
        .hms(on_if.cnt)
    );

    // ---------------------------------------------------------------
    // Reset scope and access gating
    // ---------------------------------------------------------------
    assign hold = s_q.reset_en & ~pg_s; // see RULE_07
    assign sys_act = sysrst_s | (s_q.seq == ST_DRIVE);
    assign mon_rst = s_q.reset_en & sys_act; // see RULE_02, RULE_09
    // Interface init on every backplane reset, whatever the scope
    assign vif_init = sys_act; // see RULE_03
    assign monitor_reset = mon_rst;
    assign ui_enable = ~hold & ~mon_rst; // see RULE_07
    assign wr_ok = wr & ~hold & ~mon_rst;
    assign rd_ok = rd & ~hold & ~mon_rst;
    assign tick = (s_q.tick_cnt == TICK_W'(TICK_CYCLES - 1));

    assign en_arg = bool_arg(wdata);
    assign pw_arg = en_arg;
    assign set_time = unpack_hms(wdata);
    assign time_ok = set_time.hours <= MAX_DAY_HOUR &&
                     set_time.min <= MAX_MIN_SEC &&
                     set_time.sec <= MAX_MIN_SEC;

    always_comb begin
        events = '0;
        if (wr_ok && addr == OFF_RESET_EN && !en_arg[1]) begin
            events[IRQ_ILLEGAL] = 1'b1; // see RULE_06
        end
        if (wr_ok && addr == OFF_POWER && !pw_arg[1]) begin
            events[IRQ_ILLEGAL] = 1'b1; // see RULE_18
        end
        if (wr_ok && addr == OFF_TIME && !time_ok) begin
            events[IRQ_RANGE] = 1'b1; // see RULE_12
        end
    end

    // ---------------------------------------------------------------
    // Counter control
    // ---------------------------------------------------------------
    assign tod_if.tick = tick;
    assign tod_if.clear = mon_rst;
    assign tod_if.load = wr_ok && addr == OFF_TIME && time_ok; // see RULE_10
    assign tod_if.load_val = set_time;
    // Elapsed counters run only while the chassis is powered
    assign svc_if.tick = tick & pg_s; // see RULE_14
    assign svc_if.clear = 1'b0;
    assign svc_if.load = 1'b0;
    assign svc_if.load_val = '0;
    assign on_if.tick = tick & pg_s; // see RULE_15
    assign on_if.clear = pg_s & ~s_q.pg_prev;
    assign on_if.load = 1'b0;
    assign on_if.load_val = '0;

    // ---------------------------------------------------------------
    // Next state
    // ---------------------------------------------------------------
    always_comb begin
        s_d = s_q;
        s_d.pg_prev = pg_s;
        s_d.tick_cnt = tick ? '0 : s_q.tick_cnt + 28'h000_0001;
        if (wr_ok && addr == OFF_RESET_EN && en_arg[1]) begin
            s_d.reset_en = en_arg[0]; // see RULE_05
        end
        if (wr_ok && addr == OFF_POWER && pw_arg[1]) begin
            s_d.power_cmd = pw_arg[0];
        end
        if (wr_ok && addr == OFF_IRQ_MASK) begin
            s_d.irq_mask = wdata[IRQ_W-1:0];
        end
        // Read clears, but an event in the same cycle still sets
        if (rd_ok && addr == OFF_IRQ_STATUS) begin
            s_d.irq_status = events;
        end else begin
            s_d.irq_status = s_q.irq_status | events;
        end
        s_d.rdata = '0;
        if (rd_ok) begin
            case (addr)
                OFF_RESET_EN: s_d.rdata = {31'h0000_0000, s_q.reset_en};
                OFF_POWER: s_d.rdata = {31'h0000_0000, s_q.power_cmd};
                OFF_TIME: s_d.rdata = pack_hms(tod_if.value); // see RULE_13
                OFF_SERVICE_TIME: s_d.rdata = pack_hms(svc_if.value);
                OFF_ON_TIME: s_d.rdata = pack_hms(on_if.value);
                OFF_VERSION: s_d.rdata = VERSION_VALUE; // see RULE_16
                OFF_SOURCE: s_d.rdata = {31'h0000_0000, ext_s}; // see RULE_01
                OFF_IRQ_STATUS: s_d.rdata = {30'h0000_0000, s_q.irq_status};
                OFF_IRQ_MASK: s_d.rdata = {30'h0000_0000, s_q.irq_mask};
                default: s_d.rdata = '0;
            endcase
        end
        // A whole-monitor reset must not cut short our own drive
        case (s_q.seq)
            ST_RUN: begin
                if (wr_ok && addr == OFF_RESET_NOW) begin
                    s_d.seq = ST_DRIVE; // see RULE_08
                    s_d.pulse_cnt = '0;
                end
            end
            ST_DRIVE: begin
                s_d.pulse_cnt = s_q.pulse_cnt + 8'h01;
                if (s_q.pulse_cnt == RESET_PULSE_CYCLES - 8'h01) begin
                    s_d.seq = ST_RELEASE;
                end
            end
            ST_RELEASE: begin
                // Wait for the wired line to read back released
                if (!sysrst_s) begin
                    s_d.seq = ST_RUN;
                end
            end
            default: s_d.seq = ST_RUN;
        endcase
        if (mon_rst) begin
            s_d.irq_status = '0;
            s_d.irq_mask = '0;
            s_d.rdata = '0;
        end
    end

    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            s_q <= '0; // see RULE_04
        end else if (ce) begin
            s_q <= s_d;
        end
    end

    // ---------------------------------------------------------------
    // Outputs
    // ---------------------------------------------------------------
    assign rdata = s_q.rdata;
    assign irq = |(s_q.irq_status & s_q.irq_mask);
    assign sysreset_n_o = 1'b0;
    assign sysreset_n_oe = (s_q.seq == ST_DRIVE);
    assign chassis_power_cmd = s_q.power_cmd;

    // ---------------------------------------------------------------
    // Checks
    // ---------------------------------------------------------------
    default clocking cb @(posedge clk iff ce);
    endclocking
    default disable iff (reset);

    chk_factory_default: assert property ( // see RULE_04
        $fell(reset) |-> !s_q.reset_en)
        else $error("reset enable not cleared after reset");
    chk_bool_write: assert property ( // see RULE_05
        wr_ok && addr == OFF_RESET_EN && en_arg[1]
        |=> s_q.reset_en == $past(en_arg[0]))
        else $error("reset enable not written");
    chk_illegal_arg: assert property ( // see RULE_06
        wr_ok && addr == OFF_RESET_EN && !en_arg[1]
        |=> $stable(s_q.reset_en) && s_q.irq_status[IRQ_ILLEGAL])
        else $error("illegal argument not flagged");
    chk_range_event: assert property ( // see RULE_12
        wr_ok && addr == OFF_TIME && !time_ok
        |=> s_q.irq_status[IRQ_RANGE] &&
            (tod_if.value == $past(tod_if.value) || $past(tick)))
        else $error("out-of-range time not flagged");
    chk_version_read: assert property ( // see RULE_16
        rd_ok && addr == OFF_VERSION |=> rdata == VERSION_VALUE)
        else $error("wrong version value");
    chk_drive_pulse: assert property ( // see RULE_08
        s_q.seq == ST_RUN && wr_ok && addr == OFF_RESET_NOW
        |=> sysreset_n_oe [*8])
        else $error("backplane reset not driven");
    chk_local_scope: assert property ( // see RULE_03
        sys_act && !s_q.reset_en |-> vif_init && !monitor_reset
        ##1 (s_q.irq_mask == $past(s_q.irq_mask) || $past(wr)))
        else $error("backplane reset reached monitor while disabled");
    chk_full_scope: assert property ( // see RULE_02
        sys_act && s_q.reset_en |=> s_q.irq_status == '0 && rdata == '0)
        else $error("monitor not reset by backplane reset");
    chk_hold_quiet: assert property ( // see RULE_07
        hold && rd |-> !ui_enable ##1 rdata == '0)
        else $error("held monitor still answering");
    chk_source_read: assert property ( // see RULE_01
        rd_ok && addr == OFF_SOURCE |=> rdata == {31'h0000_0000, $past(ext_s)})
        else $error("wrong supply source");
endmodule : monitor_system_commands

// ---- src/sys_cmd_pkg.sv ----
/*
 * Shared constants, types and helper functions of the monitor system
 * command block: register offsets, field layout, timing and states.
 * Assumes a single 250 MHz clock and a plain strobe-based register port.
 */
// Notes on behaviour
// RULE_01 - Power-source query answers chassis supply or external supply.
// RULE_02 - Reset-enable on: backplane reset resets the whole monitor.
// RULE_03 - Reset-enable off: backplane reset initialises only its interface.
// RULE_04 - Reset-enable leaves the factory cleared, value zero.
// RULE_05 - Nonzero or ON sets reset-enable, zero or OFF clears; query 1/0.
// RULE_06 - Illegal boolean raises illegal-parameter event, setting unchanged.
// RULE_07 - Reset-enable on and chassis down holds monitor inoperative.
// RULE_08 - Reset-now command drives backplane reset at once.
// RULE_09 - Own backplane reset follows the same reset-enable scope.
// RULE_10 - Time of day as 24-hour hour, minute, second; settable, readable.
// RULE_11 - Time of day cleared to zero at every power up.
// RULE_12 - Out-of-range time set raises range event, keeps old time.
// RULE_13 - Time query returns hour, minute, second of the front panel.
// RULE_14 - Read-only elapsed time since last service, in h/m/s; here the count restarts at power up instead.
// RULE_15 - Read-only elapsed time since latest power on, in h/m/s.
// RULE_16 - Version query returns the fixed language version number.
// RULE_17 - Seconds, minutes roll 59 to 0 with carry; hours 23 to 0.
// RULE_18 - Illegal boolean to chassis power command raises the same event.
package sys_cmd_pkg;

    // ---------------------------------------------------------------
    // Register port
    // ---------------------------------------------------------------
    localparam int ADDR_W = 8;
    localparam int DATA_W = 32;
    localparam logic [ADDR_W-1:0] OFF_RESET_EN = 8'h00;
    localparam logic [ADDR_W-1:0] OFF_POWER = 8'h04;
    localparam logic [ADDR_W-1:0] OFF_RESET_NOW = 8'h08;
    localparam logic [ADDR_W-1:0] OFF_TIME = 8'h0C;
    localparam logic [ADDR_W-1:0] OFF_SERVICE_TIME = 8'h10;
    localparam logic [ADDR_W-1:0] OFF_ON_TIME = 8'h14;
    localparam logic [ADDR_W-1:0] OFF_VERSION = 8'h18;
    localparam logic [ADDR_W-1:0] OFF_SOURCE = 8'h1C;
    localparam logic [ADDR_W-1:0] OFF_IRQ_STATUS = 8'h20;
    localparam logic [ADDR_W-1:0] OFF_IRQ_MASK = 8'h24;

    // ---------------------------------------------------------------
    // Fields
    // ---------------------------------------------------------------
    localparam int HOUR_W = 20;
    localparam int MS_W = 6;
    localparam int HOUR_LSB = 12;
    localparam int MIN_LSB = 6;
    localparam int SEC_LSB = 0;
    localparam int ARG_KIND_LSB = 30;
    localparam logic [1:0] ARG_NUMERIC = 2'h0;
    localparam logic [1:0] ARG_KEYWORD = 2'h1;
    localparam logic [29:0] KEY_OFF = 30'h0000_0000;
    localparam logic [29:0] KEY_ON = 30'h0000_0001;
    localparam logic [MS_W-1:0] MAX_MIN_SEC = 6'h3B;
    localparam logic [HOUR_W-1:0] MAX_DAY_HOUR = 20'h0_0017;
    // Version 1995.0 reported in tenths
    localparam logic [DATA_W-1:0] VERSION_VALUE = 32'h0000_4DEE;
    localparam int IRQ_W = 2;
    localparam int IRQ_ILLEGAL = 0;
    localparam int IRQ_RANGE = 1;

    // ---------------------------------------------------------------
    // Timing
    // ---------------------------------------------------------------
    localparam longint CLK_PERIOD_NS = 4;
    localparam longint SECOND_NS = 1_000_000_000;
    localparam int unsigned TICK_CYCLES_DEF =
        int'(SECOND_NS / CLK_PERIOD_NS);
    localparam int TICK_W = 28;
    localparam longint RESET_PULSE_NS = 1000;
    localparam logic [7:0] RESET_PULSE_CYCLES =
        8'((RESET_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);

    // ---------------------------------------------------------------
    // Types
    // ---------------------------------------------------------------
    typedef enum logic [1:0] {
        ST_RUN = 2'h0,
        ST_DRIVE = 2'h1,
        ST_RELEASE = 2'h3
    } seq_t;

    typedef struct packed {
        logic [HOUR_W-1:0] hours;
        logic [MS_W-1:0] min;
        logic [MS_W-1:0] sec;
    } hms_t;

    // {legal, value} of a boolean argument word
    function automatic logic [1:0] bool_arg(input logic [DATA_W-1:0] w);
        logic [1:0] kind;
        kind = w[ARG_KIND_LSB +: 2];
        if (kind == ARG_NUMERIC) begin
            return {1'b1, |w[29:0]};
        end else if (kind == ARG_KEYWORD && w[29:0] == KEY_ON) begin
            return 2'h3;
        end else if (kind == ARG_KEYWORD && w[29:0] == KEY_OFF) begin
            return 2'h2;
        end
        return 2'h0;
    endfunction : bool_arg

    function automatic logic [DATA_W-1:0] pack_hms(input hms_t t);
        logic [DATA_W-1:0] w;
        w = '0;
        w[HOUR_LSB +: HOUR_W] = t.hours;
        w[MIN_LSB +: MS_W] = t.min;
        w[SEC_LSB +: MS_W] = t.sec;
        return w;
    endfunction : pack_hms

    function automatic hms_t unpack_hms(input logic [DATA_W-1:0] w);
        hms_t t;
        t.hours = w[HOUR_LSB +: HOUR_W];
        t.min = w[MIN_LSB +: MS_W];
        t.sec = w[SEC_LSB +: MS_W];
        return t;
    endfunction : unpack_hms

endpackage : sys_cmd_pkg

// ---- src/hms_ifc.sv ----
/*
 * Link between the command block and one hour/minute/second counter.
 * Assumes both ends share the command block's clock.
 */
interface hms_ifc import sys_cmd_pkg::*; ();
    logic tick;
    logic clear;
    logic load;
    hms_t load_val;
    hms_t value;

    modport ctl(output tick, output clear, output load, output load_val,
                input value);
    modport cnt(input tick, input clear, input load, input load_val,
                output value);
endinterface : hms_ifc

// ---- src/sync2.sv ----
/*
 * Two-stage synchroniser for asynchronous pin levels.
 * Assumes inputs are slow levels; no pulse shorter than two clocks.
 */
module sync2 #(
    parameter int W = 1
) (
    // Clocking
    input wire logic clk,
    input wire logic reset,
    input wire logic ce,
    // Levels
    input wire logic [W-1:0] d,
    output logic [W-1:0] q
);
    typedef struct packed {
        logic [W-1:0] meta;
        logic [W-1:0] stable;
    } sync_state_t;

    sync_state_t s_q;
    sync_state_t s_d;

    // The first stage feeds only the second stage
    always_comb begin
        s_d.meta = d;
        s_d.stable = s_q.meta;
    end

    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            s_q <= '0;
        end else if (ce) begin
            s_q <= s_d;
        end
    end

    assign q = s_q.stable;
endmodule : sync2

// ---- src/hms_counter.sv ----
/*
 * Hour/minute/second counter advanced once per tick.
 * Assumes clear beats load and load beats tick.
 */
module hms_counter import sys_cmd_pkg::*; #(
    parameter bit WRAP_DAY = 1'b0
) (
    // Clocking
    input wire logic clk,
    input wire logic reset,
    input wire logic ce,
    // Control
    hms_ifc.cnt hms
);
    hms_t s_q;
    hms_t s_d;

    always_comb begin
        s_d = s_q;
        if (hms.clear) begin
            s_d = '0;
        end else if (hms.load) begin
            s_d = hms.load_val;
        end else if (hms.tick) begin
            if (s_q.sec != MAX_MIN_SEC) begin // see RULE_17
                s_d.sec = s_q.sec + 6'h01;
            end else begin
                s_d.sec = '0;
                if (s_q.min != MAX_MIN_SEC) begin
                    s_d.min = s_q.min + 6'h01;
                end else begin
                    s_d.min = '0;
                    if (WRAP_DAY && s_q.hours == MAX_DAY_HOUR) begin
                        s_d.hours = '0; // see RULE_17
                    end else begin
                        s_d.hours = s_q.hours + 20'h0_0001;
                    end
                end
            end
        end
    end

    // Power-up clears the count to 0,0,0
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            s_q <= '0; // see RULE_11
        end else if (ce) begin
            s_q <= s_d;
        end
    end

    assign hms.value = s_q;

    // ---------------------------------------------------------------
    // Checks
    // ---------------------------------------------------------------
    chk_sec_rollover: assert property ( // see RULE_17
        @(posedge clk iff ce) disable iff (reset)
        hms.tick && !hms.clear && !hms.load && s_q.sec == MAX_MIN_SEC
        |=> s_q.sec == '0 && s_q.min != $past(s_q.min))
        else $error("seconds did not roll over with carry");

    chk_load_value: assert property ( // see RULE_10
        @(posedge clk iff ce) disable iff (reset)
        hms.load && !hms.clear |=> s_q == $past(hms.load_val))
        else $error("loaded time not taken");
endmodule : hms_counter

// ---- test/backplane_model.sv ----
/*
 * Backplane model: the open-drain reset line with its pull-up, plus
 * other backplane sources that may sink the line.
 * Assumes the card drives the line only through its output enable.
 */
module backplane_model (
    // Card side
    input wire logic oe,
    input wire logic drv_n,
    // Other backplane sources
    input wire logic pull,
    // Resolved line
    output logic line_n
);
    timeunit 1ns;
    timeprecision 1ps;

    // Pull-up wins unless someone sinks the line; no one drives it high
    assign line_n = !((oe && !drv_n) || pull);
endmodule : backplane_model

// ---- test/tb.sv ----
/*
 * Self-checking bench of monitor_system_commands.
 * Assumes backplane_model for the reset line; read results are noted
 * in a queue by the driver and checked by a separate watcher.
 */
module tb import sys_cmd_pkg::*; ;
    timeunit 1ns;
    timeprecision 1ps;

    // Short second so that roll-over fits in a short run
    localparam int TICKS = 100;
    typedef struct {logic [DATA_W-1:0] exp; bit tol;} note_t;
    note_t notes[$];
    logic clk = 0, reset = 1, ce = 1, wr = 0, rd = 0, rd_d = 0;
    logic pull = 0, pgood = 1, ext = 0;
    logic [ADDR_W-1:0] addr = '0;
    logic [DATA_W-1:0] wdata = '0;
    logic [DATA_W-1:0] rdata;
    logic irq, line_n, oe, drv_n, vif_init, monitor_reset, ui_enable, pcmd;
    int bad_count = 0, comparisons = 0, seed = 2065;

    always #2 clk = ~clk;

    monitor_system_commands #(.TICK_CYCLES(TICKS)) DUT (
        .clk(clk), .reset(reset), .ce(ce), .addr(addr), .wdata(wdata),
        .wr(wr), .rd(rd), .rdata(rdata), .irq(irq), .sysreset_n_i(line_n),
        .sysreset_n_o(drv_n), .sysreset_n_oe(oe),
        .chassis_power_good(pgood), .external_supply(ext),
        .vif_init(vif_init), .monitor_reset(monitor_reset),
        .ui_enable(ui_enable), .chassis_power_cmd(pcmd));

    backplane_model bp (.oe(oe), .drv_n(drv_n), .pull(pull),
        .line_n(line_n));

    // ----------------------------------------------------------------
    // Helpers
    // ----------------------------------------------------------------
    function automatic logic [31:0] hms(int h, int m, int s);
        return {20'(h), 6'(m), 6'(s)};
    endfunction : hms

    // Time one second later; the tick phase is free running
    function automatic logic [31:0] plus1(logic [31:0] t);
        if (t[5:0] != 6'h3B) return t + 32'h1;
        if (t[11:6] != 6'h3B) return {t[31:12], t[11:6] + 6'h1, 6'h0};
        return {(t[31:12] == 20'h17) ? 20'h0 : t[31:12] + 20'h1, 12'h0};
    endfunction : plus1

    task automatic cmp_word(string name, note_t n, logic [31:0] got);
        comparisons++;
        if (!(got === n.exp || (n.tol && got === plus1(n.exp)))) begin
            bad_count++;
            $display("mismatch %s expected %h seen %h", name, n.exp, got);
        end
    endtask : cmp_word

    task automatic cmp_bit(string name, logic exp, logic got);
        comparisons++;
        if (got !== exp) begin
            bad_count++;
            $display("mismatch %s expected %b seen %b", name, exp, got);
        end
    endtask : cmp_bit

    // Strobes stay up so that accesses can follow with no gap
    task automatic bus(bit w, logic [7:0] a, logic [31:0] d);
        @(posedge clk);
        wr <= w;
        rd <= !w;
        addr <= a;
        wdata <= d;
    endtask : bus

    task automatic rd_chk(logic [7:0] a, logic [31:0] e, bit t = 0);
        notes.push_back('{e, t});
        bus(0, a, '0);
    endtask : rd_chk

    task automatic idle(int n);
        @(posedge clk);
        wr <= 0;
        rd <= 0;
        repeat (n - 1) @(posedge clk);
        #1;
    endtask : idle

    task automatic print_verdict;
        bad_count += notes.size();
        if (bad_count == 0 && comparisons > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask : print_verdict

    // ----------------------------------------------------------------
    // Read watcher: data stand one cycle after the strobe
    // ----------------------------------------------------------------
    always @(posedge clk) rd_d <= rd;
    always @(negedge clk) begin
        if (rd_d && notes.size() > 0) begin
            cmp_word("rdata", notes.pop_front(), rdata);
        end
    end

    initial begin
        #100000;
        bad_count++;
        print_verdict();
    end

    // ----------------------------------------------------------------
    // Scenarios
    // ----------------------------------------------------------------
    initial begin
        repeat (10) @(posedge clk);
        reset <= 0;
        // Writes to read-only places must not stick
        bus(1, OFF_SERVICE_TIME, $random(seed));
        bus(1, OFF_VERSION, 32'h0);
        rd_chk(OFF_RESET_EN, 32'h0);
        rd_chk(OFF_TIME, 32'h0, 1);
        rd_chk(OFF_SERVICE_TIME, 32'h0, 1);
        rd_chk(OFF_ON_TIME, 32'h0, 1);
        rd_chk(OFF_VERSION, VERSION_VALUE);
        rd_chk(OFF_SOURCE, 32'h0);
        rd_chk(8'h30, 32'h0);
        idle(2);
        @(posedge clk) ext <= 1;
        idle(4);
        rd_chk(OFF_SOURCE, 32'h1);
        // Legal arguments: random nonzero, zero, ON, OFF, then ON
        for (int i = 0; i < 5; i++) begin
            logic [31:0] arg;
            arg = (i == 0) ? {2'h0, 30'($random(seed) | 1)} :
                  (i == 1) ? 32'h0 : {2'h1, 29'h0, 1'(i % 2 == 0)};
            bus(1, OFF_RESET_EN, arg);
            rd_chk(OFF_RESET_EN, {31'h0, 1'(i % 2 == 0)});
            bus(1, OFF_POWER, arg);
            idle(1);
            cmp_bit("chassis_power_cmd", 1'(i % 2 == 0), pcmd);
        end
        // Illegal arguments of every kind, with interrupts masked
        bus(1, OFF_IRQ_MASK, 32'h0);
        for (int i = 0; i < 3; i++) begin
            logic [31:0] arg;
            arg = {2'(i + 1), 30'($random(seed) | 2)};
            bus(1, OFF_RESET_EN, arg);
            rd_chk(OFF_IRQ_STATUS, 32'h1);
            bus(1, OFF_POWER, arg);
            rd_chk(OFF_IRQ_STATUS, 32'h1);
            idle(1);
            cmp_bit("irq", 0, irq);
        end
        rd_chk(OFF_RESET_EN, 32'h1);
        rd_chk(OFF_POWER, 32'h1);
        bus(1, OFF_IRQ_MASK, 32'h3);
        bus(1, OFF_POWER, 32'hC000_0000);
        idle(2);
        cmp_bit("irq", 1, irq);
        rd_chk(OFF_IRQ_STATUS, 32'h1);
        idle(2);
        cmp_bit("irq", 0, irq);
        // Time of day, out-of-range fields, day roll-over
        bus(1, OFF_TIME, hms(23, 59, 59));
        rd_chk(OFF_TIME, hms(23, 59, 59), 1);
        for (int i = 0; i < 3; i++) begin
            bus(1, OFF_TIME, hms(23 + (i == 0), 59 + (i == 1), 59 + (i == 2)));
            rd_chk(OFF_IRQ_STATUS, 32'h2);
        end
        idle(TICKS + 2);
        rd_chk(OFF_TIME, hms(0, 0, 0), 1);
        // Reset-now with reset-enable off, then on
        for (int en = 0; en < 2; en++) begin
            bus(1, OFF_RESET_EN, en);
            bus(1, OFF_IRQ_MASK, 32'h3);
            bus(1, OFF_RESET_NOW, $random(seed));
            idle(1);
            cmp_bit("sysreset_n_oe", 1, oe);
            cmp_bit("line_n", 0, line_n);
            cmp_bit("vif_init", 1, vif_init);
            cmp_bit("monitor_reset", 1'(en), monitor_reset);
            idle(249);
            cmp_bit("sysreset_n_oe", 1, oe);
            idle(1);
            cmp_bit("sysreset_n_oe", 0, oe);
            idle(5);
            cmp_bit("vif_init", 0, vif_init);
            rd_chk(OFF_RESET_EN, en);
            rd_chk(OFF_IRQ_MASK, en ? 32'h0 : 32'h3);
        end
        // Reset line pulled by another card, reset-enable on
        bus(1, OFF_TIME, hms(5, 6, 7));
        idle(1);
        @(posedge clk) pull <= 1;
        idle(4);
        cmp_bit("monitor_reset", 1, monitor_reset);
        cmp_bit("sysreset_n_oe", 0, oe);
        @(posedge clk) pull <= 0;
        idle(5);
        cmp_bit("monitor_reset", 0, monitor_reset);
        rd_chk(OFF_TIME, hms(0, 0, 0), 1);
        // Chassis down with reset-enable on holds the monitor
        idle(1);
        @(posedge clk) pgood <= 0;
        idle(4);
        cmp_bit("ui_enable", 0, ui_enable);
        rd_chk(OFF_VERSION, 32'h0);
        idle(1);
        @(posedge clk) pgood <= 1;
        idle(4);
        cmp_bit("ui_enable", 1, ui_enable);
        rd_chk(OFF_ON_TIME, 32'h0, 1);
        // Clock enable low freezes the time of day
        bus(1, OFF_TIME, hms(1, 2, 3));
        idle(1);
        @(posedge clk) ce <= 0;
        idle(TICKS + 2);
        @(posedge clk) ce <= 1;
        rd_chk(OFF_TIME, hms(1, 2, 3), 1);
        idle(3);
        print_verdict();
    end
endmodule : tb
